// ===== ddc_pkg.sv
// Purpose: Constants, types and command decode for the drive device-control machine
// Assumes: Object dictionary reached by index/subindex strobes, one clock domain
// Notes: Dictionary indices are used as-is; the design never turns them into byte addresses
// Function
// - Power-up transient state left automatically
// - Rest in switch-on-disabled, indicator flashing green
// - Shutdown goes to armed idle, optional stop
// - Switch-on to switched-on; enable-op may skip it
// - Enable-operation only while supply in range
// - Steady green only operating; output stage also on while stopping
// - Disable-operation to switched-on, cancel jobs, optional stop
// - Disable-voltage: stage off at once, switch-on-disabled
// - Quick stop: ramp down, discard jobs on entry
// - Quick-stop-active left only by disable-voltage or masked error
// - Halt suspends jobs, resume when cleared
// - Masked error: stop motor, stage off, fault
// - Fault needs fault-reset edge before switch-on
// - Commands decoded from command word bits 0-3
// - Life bit copied to status bit 15
// - Halt bit zero permits, one stops
package ddc_pkg;

  localparam logic [15:0] IDX_CMD_WORD = 16'h6040;
  localparam logic [15:0] IDX_ERR_MASK = 16'h2321;
  localparam logic [7:0] SUB_FAULT_MASK = 8'h02;
  localparam logic [15:0] IDX_SHUT_OPT = 16'h605B;
  localparam logic [15:0] IDX_DISOP_OPT = 16'h605C;
  localparam logic [7:0] SUB_ZERO = 8'h00;

  localparam int BIT_SWITCH_ON = 0;
  localparam int BIT_EN_VOLT = 1;
  localparam int BIT_QUICK_STOP = 2;
  localparam int BIT_EN_OP = 3;
  localparam int BIT_FAULT_RESET = 7;
  localparam int BIT_HALT = 8;
  localparam int BIT_LIFE = 15;

  localparam logic [15:0] RST_CMD_WORD = 16'h0000;
  localparam logic [15:0] RST_FAULT_MASK = 16'h0000;
  localparam logic [15:0] RST_STOP_OPT = 16'h0000;

  typedef enum logic [8:0] {
    ST_PWRUP = 9'h001,
    ST_SOD = 9'h002,
    ST_ARMED = 9'h004,
    ST_SWON = 9'h008,
    ST_OPEN = 9'h010,
    ST_QSTOP = 9'h020,
    ST_CSTOP = 9'h040,
    ST_FREACT = 9'h080,
    ST_FAULT = 9'h100
  } ddc_state_t;

  typedef enum logic [1:0] {
    LED_OFF = 2'h0,
    LED_FLASH = 2'h1,
    LED_STEADY = 2'h2,
    LED_FAULT = 2'h3
  } ddc_led_t;

  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_SHUT = 3'h1,
    CMD_SWON = 3'h2,
    CMD_DISV = 3'h3,
    CMD_QSTOP = 3'h4,
    CMD_ENOP = 3'h5
  } ddc_cmd_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] index;
    logic [7:0] sub;
    logic [15:0] wdata;
  } ddc_dict_req_t;

  // Switch-on and disable-operation share one code; the state tells them apart
  function automatic ddc_cmd_t ddc_decode(input logic [3:0] b);
    ddc_cmd_t c;
    c = CMD_NONE;
    if (!b[BIT_EN_VOLT]) begin
      c = CMD_DISV;
    end else if (!b[BIT_QUICK_STOP]) begin
      c = CMD_QSTOP;
    end else if (!b[BIT_SWITCH_ON]) begin
      c = CMD_SHUT;
    end else if (b[BIT_EN_OP]) begin
      c = CMD_ENOP;
    end else begin
      c = CMD_SWON;
    end
    return c;
  endfunction

endpackage

// ===== ddc_drive_ctrl.sv
// Purpose: Drive device-control state machine driven by a command word
// Assumes: Dictionary strobes and error flags synchronous to clock
// Notes: A stop option of zero switches at once; nonzero waits for standstill
`timescale 1ns/1ps
`default_nettype none

module ddc_drive_ctrl (
  input wire logic clock,
  input wire logic rst_b,
  input wire ddc_pkg::ddc_dict_req_t dict_req,
  input wire logic supply_ok,
  input wire logic motor_still,
  input wire logic [15:0] err_flags,
  output logic [15:0] dict_rdata,
  output ddc_pkg::ddc_state_t drive_state,
  output logic stage_en,
  output ddc_pkg::ddc_led_t led_mode,
  output logic move_hold,
  output logic move_cancel,
  output logic stop_req,
  output logic qs_ramp,
  output logic status_life
);

  typedef struct packed {
    ddc_pkg::ddc_state_t st;
    ddc_pkg::ddc_state_t tgt;
    logic [15:0] cmd;
    logic [15:0] fmask;
    logic [15:0] opt_shut;
    logic [15:0] opt_disop;
    logic fr_prev;
    logic [15:0] rdata;
    logic stage;
    ddc_pkg::ddc_led_t led;
    logic hold;
    logic cancel;
    logic stop;
    logic qsr;
    logic life;
  } ddc_regs_t;

  localparam ddc_regs_t REGS_RESET = '{
    st: ddc_pkg::ST_PWRUP,
    tgt: ddc_pkg::ST_SOD,
    cmd: ddc_pkg::RST_CMD_WORD,
    fmask: ddc_pkg::RST_FAULT_MASK,
    opt_shut: ddc_pkg::RST_STOP_OPT,
    opt_disop: ddc_pkg::RST_STOP_OPT,
    fr_prev: 1'b0,
    rdata: 16'h0000,
    stage: 1'b0,
    led: ddc_pkg::LED_OFF,
    hold: 1'b0,
    cancel: 1'b0,
    stop: 1'b0,
    qsr: 1'b0,
    life: 1'b0
  };

  ddc_regs_t r_q;
  ddc_regs_t r_d;

  always_comb begin
    ddc_pkg::ddc_cmd_t cmd;
    logic fr_edge;
    logic err;
    cmd = ddc_pkg::ddc_decode(r_q.cmd[3:0]);
    fr_edge = r_q.cmd[ddc_pkg::BIT_FAULT_RESET] & ~r_q.fr_prev;
    err = |(err_flags & r_q.fmask);
    r_d = r_q;
    r_d.cancel = 1'b0;
    r_d.fr_prev = r_q.cmd[ddc_pkg::BIT_FAULT_RESET];

    if (dict_req.wr) begin
      if (dict_req.index == ddc_pkg::IDX_CMD_WORD && dict_req.sub == ddc_pkg::SUB_ZERO) begin
        r_d.cmd = dict_req.wdata;
      end
      if (dict_req.index == ddc_pkg::IDX_ERR_MASK && dict_req.sub == ddc_pkg::SUB_FAULT_MASK) begin
        r_d.fmask = dict_req.wdata;
      end
      if (dict_req.index == ddc_pkg::IDX_SHUT_OPT && dict_req.sub == ddc_pkg::SUB_ZERO) begin
        r_d.opt_shut = dict_req.wdata;
      end
      if (dict_req.index == ddc_pkg::IDX_DISOP_OPT && dict_req.sub == ddc_pkg::SUB_ZERO) begin
        r_d.opt_disop = dict_req.wdata;
      end
    end
    if (dict_req.rd) begin
      r_d.rdata = 16'h0000;
      if (dict_req.index == ddc_pkg::IDX_CMD_WORD && dict_req.sub == ddc_pkg::SUB_ZERO) begin
        r_d.rdata = r_q.cmd;
      end
      if (dict_req.index == ddc_pkg::IDX_ERR_MASK && dict_req.sub == ddc_pkg::SUB_FAULT_MASK) begin
        r_d.rdata = r_q.fmask;
      end
      if (dict_req.index == ddc_pkg::IDX_SHUT_OPT && dict_req.sub == ddc_pkg::SUB_ZERO) begin
        r_d.rdata = r_q.opt_shut;
      end
      if (dict_req.index == ddc_pkg::IDX_DISOP_OPT && dict_req.sub == ddc_pkg::SUB_ZERO) begin
        r_d.rdata = r_q.opt_disop;
      end
    end

    // Commands with no transition from the current state fall through untouched
    case (r_q.st)
      ddc_pkg::ST_PWRUP: begin
        r_d.st = ddc_pkg::ST_SOD;
      end
      ddc_pkg::ST_SOD: begin
        if (cmd == ddc_pkg::CMD_SHUT) begin
          r_d.st = ddc_pkg::ST_ARMED;
        end
      end
      ddc_pkg::ST_ARMED: begin
        if (cmd == ddc_pkg::CMD_SWON) begin
          r_d.st = ddc_pkg::ST_SWON;
        end else if (cmd == ddc_pkg::CMD_ENOP && supply_ok) begin
          r_d.st = ddc_pkg::ST_OPEN;
        end else if (cmd == ddc_pkg::CMD_DISV || cmd == ddc_pkg::CMD_QSTOP) begin
          r_d.st = ddc_pkg::ST_SOD;
        end
      end
      ddc_pkg::ST_SWON: begin
        if (cmd == ddc_pkg::CMD_ENOP && supply_ok) begin
          r_d.st = ddc_pkg::ST_OPEN;
        end else if (cmd == ddc_pkg::CMD_SHUT) begin
          r_d.st = ddc_pkg::ST_ARMED;
        end else if (cmd == ddc_pkg::CMD_DISV || cmd == ddc_pkg::CMD_QSTOP) begin
          r_d.st = ddc_pkg::ST_SOD;
        end
      end
      ddc_pkg::ST_OPEN: begin
        if (cmd == ddc_pkg::CMD_DISV) begin
          r_d.st = ddc_pkg::ST_SOD;
        end else if (cmd == ddc_pkg::CMD_QSTOP) begin
          r_d.st = ddc_pkg::ST_QSTOP;
          r_d.cancel = 1'b1;
        end else if (cmd == ddc_pkg::CMD_SWON) begin
          r_d.cancel = 1'b1;
          if (r_q.opt_disop != ddc_pkg::RST_STOP_OPT) begin
            r_d.st = ddc_pkg::ST_CSTOP;
            r_d.tgt = ddc_pkg::ST_SWON;
          end else begin
            r_d.st = ddc_pkg::ST_SWON;
          end
        end else if (cmd == ddc_pkg::CMD_SHUT) begin
          if (r_q.opt_shut != ddc_pkg::RST_STOP_OPT) begin
            r_d.st = ddc_pkg::ST_CSTOP;
            r_d.tgt = ddc_pkg::ST_ARMED;
          end else begin
            r_d.st = ddc_pkg::ST_ARMED;
          end
        end
      end
      ddc_pkg::ST_CSTOP: begin
        if (cmd == ddc_pkg::CMD_DISV) begin
          r_d.st = ddc_pkg::ST_SOD;
        end else if (motor_still) begin
          r_d.st = r_q.tgt;
        end
      end
      ddc_pkg::ST_QSTOP: begin
        if (cmd == ddc_pkg::CMD_DISV) begin
          r_d.st = ddc_pkg::ST_SOD;
        end
      end
      ddc_pkg::ST_FREACT: begin
        if (motor_still) begin
          r_d.st = ddc_pkg::ST_FAULT;
        end
      end
      ddc_pkg::ST_FAULT: begin
        // Only the acknowledge edge leaves here, so no switch-on can slip past
        if (fr_edge) begin
          r_d.st = ddc_pkg::ST_SOD;
        end
      end
      default: begin
        r_d.st = ddc_pkg::ST_SOD;
      end
    endcase

    // Error wins over any command in the same cycle, except the fault-reset edge in fault
    if (err && r_q.st != ddc_pkg::ST_FREACT && r_q.st != ddc_pkg::ST_FAULT) begin
      r_d.st = ddc_pkg::ST_FREACT;
      r_d.cancel = 1'b0;
    end

    // Stage stays on during ramps so the motor can be braked electrically
    r_d.stage = (r_d.st == ddc_pkg::ST_OPEN) || (r_d.st == ddc_pkg::ST_QSTOP) ||
                (r_d.st == ddc_pkg::ST_CSTOP) ||
                (r_d.st == ddc_pkg::ST_FREACT && r_q.stage);
    r_d.stop = (r_d.st == ddc_pkg::ST_CSTOP) || (r_d.st == ddc_pkg::ST_FREACT);
    r_d.qsr = (r_d.st == ddc_pkg::ST_QSTOP);
    r_d.hold = r_q.cmd[ddc_pkg::BIT_HALT] && (r_d.st == ddc_pkg::ST_OPEN);
    r_d.life = r_q.cmd[ddc_pkg::BIT_LIFE];
    case (r_d.st)
      ddc_pkg::ST_OPEN: begin
        r_d.led = ddc_pkg::LED_STEADY;
      end
      ddc_pkg::ST_FREACT, ddc_pkg::ST_FAULT: begin
        r_d.led = ddc_pkg::LED_FAULT;
      end
      ddc_pkg::ST_PWRUP: begin
        r_d.led = ddc_pkg::LED_OFF;
      end
      default: begin
        r_d.led = ddc_pkg::LED_FLASH;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      r_q <= REGS_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  assign dict_rdata = r_q.rdata;
  assign drive_state = r_q.st;
  assign stage_en = r_q.stage;
  assign led_mode = r_q.led;
  assign move_hold = r_q.hold;
  assign move_cancel = r_q.cancel;
  assign stop_req = r_q.stop;
  assign qs_ramp = r_q.qsr;
  assign status_life = r_q.life;

endmodule

`default_nettype wire

// ===== ddc_ctrl_monitor.sv
// Purpose: Port checker for the drive control machine
// Assumes: One clock, synchronous active-low reset
// Notes: Bound onto every instance of the machine
`timescale 1ns/1ps
`default_nettype none
module ddc_ctrl_monitor (
  input wire logic clock,
  input wire logic rst_b,
  input wire ddc_pkg::ddc_dict_req_t dict_req,
  input wire logic supply_ok,
  input wire ddc_pkg::ddc_state_t drive_state,
  input wire logic stage_en,
  input wire logic move_cancel,
  input wire logic qs_ramp,
  input wire logic status_life
);
  logic cw;
  assign cw = dict_req.wr && dict_req.index == ddc_pkg::IDX_CMD_WORD
    && dict_req.sub == ddc_pkg::SUB_ZERO;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Lone write, so the mirrored bit has one source
  sequence s_cw_alone;
    cw ##1 !cw;
  endsequence
  sequence s_left_fault;
    drive_state == ddc_pkg::ST_FAULT ##1 drive_state != ddc_pkg::ST_FAULT;
  endsequence
  a_pwrup_passes: assert property (drive_state == ddc_pkg::ST_PWRUP
    |=> drive_state == ddc_pkg::ST_SOD) else $error("transient state held");
  a_stage_gated: assert property (stage_en |-> drive_state inside
    {ddc_pkg::ST_OPEN, ddc_pkg::ST_QSTOP, ddc_pkg::ST_CSTOP, ddc_pkg::ST_FREACT})
    else $error("stage on in idle state");
  a_supply_gate: assert property (drive_state == ddc_pkg::ST_OPEN
    && $past(drive_state) != ddc_pkg::ST_OPEN |-> $past(supply_ok))
    else $error("enabled without supply");
  a_qs_entry: assert property (drive_state == ddc_pkg::ST_QSTOP
    && $past(drive_state) == ddc_pkg::ST_OPEN |-> move_cancel && qs_ramp)
    else $error("quick stop entry wrong");
  a_dop_cancel: assert property (drive_state == ddc_pkg::ST_SWON
    && $past(drive_state) == ddc_pkg::ST_OPEN |-> move_cancel)
    else $error("jobs kept on disable operation");
  a_qs_exit: assert property (drive_state == ddc_pkg::ST_QSTOP ##1
    drive_state != ddc_pkg::ST_QSTOP |-> drive_state inside
    {ddc_pkg::ST_SOD, ddc_pkg::ST_FREACT}) else $error("quick stop left wrongly");
  a_fault_dark: assert property (drive_state == ddc_pkg::ST_FAULT
    |-> !stage_en) else $error("stage on in fault");
  a_fault_exit: assert property (s_left_fault
    |-> drive_state == ddc_pkg::ST_SOD) else $error("fault left wrongly");
  a_life_mirror: assert property (s_cw_alone
    |=> status_life == $past(dict_req.wdata[15], 2)) else $error("life bit lost");
endmodule
bind ddc_drive_ctrl ddc_ctrl_monitor mon (.clock, .rst_b, .dict_req, .supply_ok,
  .drive_state, .stage_en, .move_cancel, .qs_ramp, .status_life);
`default_nettype wire

// ===== ddc_master.sv
// Purpose: Fieldbus master model issuing dictionary accesses
// Assumes: Strobes sampled on the rising clock edge
// Notes: Released index, subindex and data fields show inverted values, strobes go low, so stale data never passes
`timescale 1ns/1ps
`default_nettype none
module ddc_master (
  input wire logic clock,
  output ddc_pkg::ddc_dict_req_t dict_req,
  input wire logic [15:0] dict_rdata
);
  initial dict_req = '0;
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] sb,
                      input logic [15:0] d, output logic [15:0] q);
    @(posedge clock);
    dict_req <= {w, ~w, idx, sb, d};
    @(posedge clock);
    dict_req <= {1'b0, 1'b0, ~idx, ~sb, ~d};
    #1;
    q = dict_rdata;
  endtask
endmodule
`default_nettype wire

// ===== drive_device_control_fsm_test.sv
// Purpose: Self-checking bench for the drive control machine
// Assumes: Master model issues all dictionary accesses
// Notes: Every run ends in tally_and_finish
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module drive_device_control_fsm_test;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic supply_ok = 1'b1;
  logic motor_still = 1'b0;
  logic [15:0] err_flags = 16'h0000;
  ddc_pkg::ddc_dict_req_t dict_req;
  logic [15:0] dict_rdata;
  ddc_pkg::ddc_state_t drive_state;
  ddc_pkg::ddc_led_t led_mode;
  logic stage_en, move_hold, move_cancel, stop_req, qs_ramp, status_life;
  logic [15:0] q;
  int err_count = 0;
  int check_count = 0;
  always #25 clock = ~clock;
  ddc_master m (.clock, .dict_req, .dict_rdata);
  ddc_drive_ctrl uut (.clock, .rst_b, .dict_req, .supply_ok, .motor_still, .err_flags,
    .dict_rdata, .drive_state, .stage_en, .led_mode, .move_hold, .move_cancel,
    .stop_req, .qs_ramp, .status_life);
  task automatic cmd(input logic [15:0] w, input ddc_pkg::ddc_state_t s);
    m.xfer(1'b1, ddc_pkg::IDX_CMD_WORD, ddc_pkg::SUB_ZERO, w, q);
    repeat (2) @(posedge clock);
    #1;
    `CHK("state", s, drive_state)
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clock);
    err_count++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    #1;
    `CHK("state", ddc_pkg::ST_SOD, drive_state)
    `CHK("led", ddc_pkg::LED_FLASH, led_mode)
    `CHK("stage", 1'b0, stage_en)
    m.xfer(1'b0, ddc_pkg::IDX_CMD_WORD, ddc_pkg::SUB_ZERO, 16'h0000, q);
    `CHK("cmd word", 16'h0000, q)
    m.xfer(1'b0, 16'h1234, 8'h00, 16'h0000, q);
    `CHK("unmapped", 16'h0000, q)
    cmd(16'h0007, ddc_pkg::ST_SOD);
    $display("reset test done");
    cmd(16'h0006, ddc_pkg::ST_ARMED);
    cmd(16'h0007, ddc_pkg::ST_SWON);
    @(posedge clock);
    supply_ok <= 1'b0;
    cmd(16'h000F, ddc_pkg::ST_SWON);
    @(posedge clock);
    supply_ok <= 1'b1;
    cmd(16'h000F, ddc_pkg::ST_OPEN);
    `CHK("stage", 1'b1, stage_en)
    `CHK("led", ddc_pkg::LED_STEADY, led_mode)
    cmd(16'h810F, ddc_pkg::ST_OPEN);
    `CHK("hold", 1'b1, move_hold)
    `CHK("life", 1'b1, status_life)
    m.xfer(1'b0, ddc_pkg::IDX_CMD_WORD, ddc_pkg::SUB_ZERO, 16'h0000, q);
    `CHK("cmd word", 16'h810F, q)
    cmd(16'h000F, ddc_pkg::ST_OPEN);
    `CHK("hold", 1'b0, move_hold)
    cmd(16'h0007, ddc_pkg::ST_SWON);
    `CHK("stage", 1'b0, stage_en)
    $display("enable test done");
    cmd(16'h000F, ddc_pkg::ST_OPEN);
    cmd(16'h000B, ddc_pkg::ST_QSTOP);
    `CHK("ramp", 1'b1, qs_ramp)
    cmd(16'h000F, ddc_pkg::ST_QSTOP);
    cmd(16'h0000, ddc_pkg::ST_SOD);
    cmd(16'h0006, ddc_pkg::ST_ARMED);
    cmd(16'h000F, ddc_pkg::ST_OPEN);
    cmd(16'h0000, ddc_pkg::ST_SOD);
    `CHK("stage", 1'b0, stage_en)
    $display("stop test done");
    m.xfer(1'b1, ddc_pkg::IDX_DISOP_OPT, ddc_pkg::SUB_ZERO, 16'h0001, q);
    cmd(16'h0006, ddc_pkg::ST_ARMED);
    cmd(16'h000F, ddc_pkg::ST_OPEN);
    cmd(16'h0007, ddc_pkg::ST_CSTOP);
    `CHK("stop", 1'b1, stop_req)
    @(posedge clock);
    motor_still <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    `CHK("state", ddc_pkg::ST_SWON, drive_state)
    `CHK("stop", 1'b0, stop_req)
    @(posedge clock);
    motor_still <= 1'b0;
    cmd(16'h000F, ddc_pkg::ST_OPEN);
    cmd(16'h0006, ddc_pkg::ST_ARMED);
    $display("controlled stop test done");
    m.xfer(1'b1, ddc_pkg::IDX_ERR_MASK, ddc_pkg::SUB_FAULT_MASK, 16'h0001, q);
    m.xfer(1'b0, ddc_pkg::IDX_ERR_MASK, ddc_pkg::SUB_FAULT_MASK, 16'h0000, q);
    `CHK("fault mask", 16'h0001, q)
    cmd(16'h0006, ddc_pkg::ST_ARMED);
    @(posedge clock);
    err_flags <= 16'h0002;
    cmd(16'h000F, ddc_pkg::ST_OPEN);
    @(posedge clock);
    err_flags <= 16'h0003;
    repeat (2) @(posedge clock);
    #1;
    `CHK("state", ddc_pkg::ST_FREACT, drive_state)
    `CHK("stop", 1'b1, stop_req)
    @(posedge clock);
    motor_still <= 1'b1;
    err_flags <= 16'h0000;
    repeat (2) @(posedge clock);
    #1;
    `CHK("state", ddc_pkg::ST_FAULT, drive_state)
    `CHK("stage", 1'b0, stage_en)
    `CHK("led", ddc_pkg::LED_FAULT, led_mode)
    cmd(16'h0006, ddc_pkg::ST_FAULT);
    cmd(16'h0000, ddc_pkg::ST_FAULT);
    cmd(16'h0080, ddc_pkg::ST_SOD);
    $display("fault test done");
    cmd(16'h0006, ddc_pkg::ST_ARMED);
    cmd(16'h000F, ddc_pkg::ST_OPEN);
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    #1;
    `CHK("state", ddc_pkg::ST_SOD, drive_state)
    `CHK("stage", 1'b0, stage_en)
    m.xfer(1'b0, ddc_pkg::IDX_ERR_MASK, ddc_pkg::SUB_FAULT_MASK, 16'h0000, q);
    `CHK("fault mask", 16'h0000, q)
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
